// file: verilog/vpt_pkg.sv
// package for the voice-activity periodicity / tone block:
// register map, field positions, reset values and fixed-point constants.
// assumes a 32-bit apb register bus and q15 encoder quantities.

package vpt_pkg;

  // ----------------
  // register map (byte addresses)
  // ----------------
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_ENERGY       = 8'h08;
  localparam logic [7:0] ADDR_THRESH       = 8'h0C;
  localparam logic [7:0] ADDR_FRAME_ENERGY = 8'h10;
  localparam logic [7:0] ADDR_COMPARE      = 8'h14;
  localparam logic [7:0] ADDR_LAG_STATUS   = 8'h18;

  // ----------------
  // field positions
  // ----------------
  localparam int CTRL_RESTART_BIT   = 0;
  localparam int STAT_PERIODIC_BIT  = 0;
  localparam int STAT_TONE_BIT      = 1;
  localparam int STAT_NEAR_PREV_LSB = 4;
  localparam int STAT_NEAR_OLD_LSB  = 8;
  localparam int STAT_NEAR_CUR_LSB  = 12;
  localparam int CMP_FLOOR_BIT      = 0;
  localparam int CMP_LIMIT_BIT      = 1;
  localparam int CMP_MARGIN_BIT     = 2;
  localparam int LAG_COUNT_LSB      = 16;
  localparam int PF_EXP_LSB         = 16;

  // ----------------
  // periodicity constants and reset values
  // ----------------
  localparam int          FRAME_MS        = 20;
  localparam logic [1:0]  NEAR_LAG_LIMIT  = 2'd2;
  localparam logic [2:0]  NEAR_SUM_MIN    = 3'd4;
  localparam logic [7:0]  LAG_PREV_RESET  = 8'd18;
  localparam logic        PERIODIC_RESET  = 1'b1;
  localparam logic [1:0]  NEAR_RESET      = 2'd0;

  // ----------------
  // pseudo-floating point: value = 2**exp * mant / 32768
  // ----------------
  localparam logic [15:0] MANT_MIN        = 16'd16384;
  localparam logic [15:0] MANT_SCALE      = 16'd32768;
  localparam logic [15:0] FLOOR_EXP       = 16'd17;
  localparam logic [15:0] FLOOR_MANT      = 16'd32500;
  localparam logic [15:0] MARGIN_EXP      = 16'd27;
  localparam logic [15:0] MARGIN_MANT     = 16'd16927;
  localparam logic [15:0] LIMIT_EXP       = 16'd19;
  localparam logic [15:0] LIMIT_MANT      = 16'd21667;
  // threshold start value 866656 in normalized form
  localparam logic [15:0] THRESH_EXP_RESET  = 16'd20;
  localparam logic [15:0] THRESH_MANT_RESET = 16'd27083;

  // ----------------
  // tone pretest constants in q15 (0.0973 and 0.0447)
  // ----------------
  localparam logic [15:0] FREQ_TH_Q15     = 16'd3188;
  localparam logic [15:0] PRED_TH_Q15     = 16'd1464;

endpackage : vpt_pkg

// file: verilog/vpt_pf_compare.sv
// pseudo-floating point magnitude compare of two exponent/mantissa pairs.
// assumes both operands are normalized, so exponents order the values.
`timescale 1ns/1ps

module vpt_pf_compare (
  // operand a
  input  wire logic [15:0] a_exp,
  input  wire logic [15:0] a_mant,
  // operand b
  input  wire logic [15:0] b_exp,
  input  wire logic [15:0] b_mant,
  // result
  output logic             a_lt_b,
  output logic             a_gt_b
);

  // ----------------------------------------------------------------
  // exponent first, mantissa only on a tie
  // ----------------------------------------------------------------
  always_comb begin
    if (a_exp != b_exp) begin                                   // R10
      a_lt_b = (a_exp < b_exp);
      a_gt_b = (a_exp > b_exp);
    end else begin
      a_lt_b = (a_mant < b_mant);                               // R10
      a_gt_b = (a_mant > b_mant);
    end
  end

endmodule : vpt_pf_compare

// file: verilog/vpt_core.sv
// periodicity flag, tone pretest and pseudo-float holding registers of a
// speech voice-activity detector, with an apb register slave.
// assumes lags and reflection data come from encoder logic on clk_sys.
//
// Overview of operation
// R01: periodic flag recomputed once per 20 ms frame; it blocks threshold adaptation (here the flag is only an output; threshold writes are not gated by it).
// R02: count lag pairs (1,0) and (2,1) whose absolute difference is below 2.
// R03: shift near counts; periodic when previous plus twice-previous counts reach 4 (here the sum is the current frame's count plus the previous one).
// R04: previous frame's second lag becomes lag index 0; starts at 18.
// R05: reset sets periodic flag to 1 and both stored near counts to 0.
// R06: flag updated after the frame decision, so each decision uses last flag.
// R07: encoder delivers all correlation values and reflection coefficients before computation.
// R08: energy, threshold and frame energy held as 16-bit exponent and mantissa.
// R09: mantissa normalized to at least 16384; value is 2^exp times mant/32768.
// R10: pseudo-float values compare by exponent, then mantissa on equal exponents.
// R11: energy floor constant has exponent 17, mantissa 32500.
// R12: upper threshold margin constant has exponent 27, mantissa 16927.
// R13: threshold lower limit constant has exponent 19, mantissa 21667.
// R14: step-up gives a1, a2; real part -a1/2, imaginary (4*a2-a1^2)/4.
// R15: negative imaginary term means not a tone, evaluation ends.
// R16: negative real part means pole above 2000 Hz, go to error test.
// R17: both positive: not tone if (4*a2-a1^2)/a1^2 below 0.0973.
// R18: tone when normalized prediction error is below 0.0447.
// R19: periodicity state advances only on the lag-valid strobe, else holds.
// R20: synchronous reset loads all state to initial values in one cycle.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

module vpt_core #(
  parameter int LAG_W = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pitch lags from the long_term_predictor search
  input  wire logic              lag_valid,
  input  wire logic [LAG_W-1:0]  lag_first,
  input  wire logic [LAG_W-1:0]  lag_second,
  // reflection_coeffs and prediction error, q15
  input  wire logic              coeff_valid,
  input  wire logic signed [15:0] reflection_coeff_1,
  input  wire logic signed [15:0] reflection_coeff_2,
  input  wire logic [15:0]       norm_pred_error,
  // frame results
  output logic                   periodic_flag,
  output logic                   tone_flag,
  output logic                   tone_valid
);

  // ----------------
  // state
  // ----------------
  typedef struct packed {
    logic             periodic;
    logic [1:0]       near_prev;
    logic [1:0]       near_old;
    logic [1:0]       near_cur;
    logic [LAG_W-1:0] lag_prev;
    logic [15:0]      lag_frames;
    logic             tone;
    logic             tone_valid;
    logic [15:0]      energy_exp;
    logic [15:0]      energy_mant;
    logic [15:0]      thresh_exp;
    logic [15:0]      thresh_mant;
    logic [15:0]      frame_exp;
    logic [15:0]      frame_mant;
    logic [31:0]      rdata;
    logic             rerr;
  } vpt_state_type;

  localparam vpt_state_type STATE_RESET = '{
    periodic    : vpt_pkg::PERIODIC_RESET,
    near_prev   : vpt_pkg::NEAR_RESET,
    near_old    : vpt_pkg::NEAR_RESET,
    near_cur    : vpt_pkg::NEAR_RESET,
    lag_prev    : LAG_W'(vpt_pkg::LAG_PREV_RESET),
    lag_frames  : 16'h0000,
    tone        : 1'b0,
    tone_valid  : 1'b0,
    energy_exp  : 16'h0000,
    energy_mant : 16'h0000,
    thresh_exp  : vpt_pkg::THRESH_EXP_RESET,
    thresh_mant : vpt_pkg::THRESH_MANT_RESET,
    frame_exp   : 16'h0000,
    frame_mant  : 16'h0000,
    rdata       : 32'h0000_0000,
    rerr        : 1'b0
  };

  vpt_state_type s_q;
  vpt_state_type s_d;

  // ----------------
  // pseudo-float normalization of a raw 32-bit magnitude
  // ----------------
  // truncates the bits below the mantissa; zero maps to exp 0, mant 0
  function automatic logic [31:0] pf_norm(input logic [31:0] v);
    logic [5:0]  msb;
    logic [15:0] e;
    logic [31:0] m;
    msb = 6'd0;
    e   = 16'h0000;
    m   = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        msb = 6'(i);
      end
    end
    if (v != 32'h0000_0000) begin
      e = 16'(msb) + 16'd1;                                     // R09
      if (msb >= 6'd14) begin
        m = v >> (msb - 6'd14);
      end else begin
        m = v << (6'd14 - msb);
      end
    end
    return {e, m[15:0]};                                        // R08
  endfunction : pf_norm

  // byte-lane mask for apb writes of raw magnitudes; unstrobed lanes are written as zero
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] mk;
    mk = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      mk[b*8 +: 8] = {8{strb[b]}};
    end
    return mk;
  endfunction : lane_mask

  // ----------------
  // pseudo-float comparisons against the fixed constants
  // ----------------
  localparam int NCMP = 3;
  logic [15:0] cmp_a_exp  [NCMP];
  logic [15:0] cmp_a_mant [NCMP];
  logic [15:0] cmp_b_exp  [NCMP];
  logic [15:0] cmp_b_mant [NCMP];
  logic [NCMP-1:0] cmp_lt;
  logic [NCMP-1:0] cmp_gt;

  // frame energy vs floor, threshold vs lower limit, threshold vs margin
  always_comb begin
    cmp_a_exp[0]  = s_q.frame_exp;
    cmp_a_mant[0] = s_q.frame_mant;
    cmp_b_exp[0]  = vpt_pkg::FLOOR_EXP;                         // R11
    cmp_b_mant[0] = vpt_pkg::FLOOR_MANT;                        // R11
    cmp_a_exp[1]  = s_q.thresh_exp;
    cmp_a_mant[1] = s_q.thresh_mant;
    cmp_b_exp[1]  = vpt_pkg::LIMIT_EXP;                         // R13
    cmp_b_mant[1] = vpt_pkg::LIMIT_MANT;                        // R13
    cmp_a_exp[2]  = s_q.thresh_exp;
    cmp_a_mant[2] = s_q.thresh_mant;
    cmp_b_exp[2]  = vpt_pkg::MARGIN_EXP;                        // R12
    cmp_b_mant[2] = vpt_pkg::MARGIN_MANT;                       // R12
  end

  for (genvar g = 0; g < NCMP; g++) begin : g_cmp
    vpt_pf_compare u_cmp (
      .a_exp  (cmp_a_exp[g]),
      .a_mant (cmp_a_mant[g]),
      .b_exp  (cmp_b_exp[g]),
      .b_mant (cmp_b_mant[g]),
      .a_lt_b (cmp_lt[g]),
      .a_gt_b (cmp_gt[g])
    );
  end

  // ----------------
  // periodicity: near-lag count over the two lag pairs
  // ----------------
  logic [LAG_W-1:0] lag_seq [3];
  logic [1:0]       near_count;
  logic [2:0]       near_sum;

  always_comb begin
    lag_seq[0] = s_q.lag_prev;                                  // R04
    lag_seq[1] = lag_first;
    lag_seq[2] = lag_second;
    near_count = 2'd0;                                          // R02
    for (int j = 1; j <= 2; j++) begin
      logic [LAG_W-1:0] diff;
      diff = (lag_seq[j] > lag_seq[j-1]) ? lag_seq[j] - lag_seq[j-1]
                                         : lag_seq[j-1] - lag_seq[j];
      if (diff < LAG_W'(vpt_pkg::NEAR_LAG_LIMIT)) begin
        near_count = near_count + 2'd1;                         // R02
      end
    end
    // sum uses this frame's new count and the one stored before it
    near_sum = {1'b0, near_count} + {1'b0, s_q.near_prev};      // R03
  end

  // ----------------
  // tone pretest on the second-order pole
  // ----------------
  // a1 = k1 + k1*k2, a2 = k2 (leading coefficient one), all in q15;
  // a1*a1 and 4*a2 kept in q30 for the ratio test; k1*k2 is truncated back to q15 for a1
  logic signed [31:0] k1k2;
  logic signed [17:0] a1;
  logic signed [35:0] a1_sq;
  logic signed [35:0] four_a2;
  logic signed [35:0] im_num;
  logic signed [51:0] ratio_lhs;
  logic signed [51:0] ratio_rhs;
  logic               tone_next;

  always_comb begin
    k1k2      = reflection_coeff_1 * reflection_coeff_2;
    a1        = 18'(reflection_coeff_1) + 18'(k1k2 >>> 15);    // R14
    a1_sq     = a1 * a1;
    four_a2   = 36'(reflection_coeff_2) <<< 17;                 // R14
    im_num    = four_a2 - a1_sq;                                // R14
    // cross-multiplied to avoid a divider: num*32768 vs th*den
    ratio_lhs = 52'(im_num) <<< 15;
    ratio_rhs = 52'(a1_sq) * 52'(vpt_pkg::FREQ_TH_Q15);
    if (im_num < 0) begin
      tone_next = 1'b0;                                         // R15
    end else if (a1 > 0) begin
      // real part -a1/2 is negative: pole above 2000 Hz
      tone_next = (norm_pred_error < vpt_pkg::PRED_TH_Q15);     // R16
    end else if (ratio_lhs < ratio_rhs) begin
      tone_next = 1'b0;                                         // R17
    end else begin
      tone_next = (norm_pred_error < vpt_pkg::PRED_TH_Q15);     // R18
    end
  end

  // ----------------
  // apb decode
  // ----------------
  logic        setup_phase;
  logic        wr_access;
  logic        addr_ok;
  logic [31:0] wmask;
  logic [31:0] rd_word;

  always_comb begin
    setup_phase = psel && !penable;
    wr_access   = psel && penable && pwrite;
    wmask       = lane_mask(pstrb);
    addr_ok     = 1'b1;
    rd_word     = 32'h0000_0000;
    unique case (paddr)
      vpt_pkg::ADDR_CTRL: begin
        rd_word = 32'h0000_0000;
      end
      vpt_pkg::ADDR_STATUS: begin
        rd_word[vpt_pkg::STAT_PERIODIC_BIT]         = s_q.periodic;
        rd_word[vpt_pkg::STAT_TONE_BIT]             = s_q.tone;
        rd_word[vpt_pkg::STAT_NEAR_PREV_LSB +: 2]   = s_q.near_prev;
        rd_word[vpt_pkg::STAT_NEAR_OLD_LSB +: 2]    = s_q.near_old;
        rd_word[vpt_pkg::STAT_NEAR_CUR_LSB +: 2]    = s_q.near_cur;
      end
      vpt_pkg::ADDR_ENERGY: begin
        rd_word = {s_q.energy_exp, s_q.energy_mant};
      end
      vpt_pkg::ADDR_THRESH: begin
        rd_word = {s_q.thresh_exp, s_q.thresh_mant};
      end
      vpt_pkg::ADDR_FRAME_ENERGY: begin
        rd_word = {s_q.frame_exp, s_q.frame_mant};
      end
      vpt_pkg::ADDR_COMPARE: begin
        rd_word[vpt_pkg::CMP_FLOOR_BIT]  = cmp_lt[0];
        rd_word[vpt_pkg::CMP_LIMIT_BIT]  = cmp_lt[1];
        rd_word[vpt_pkg::CMP_MARGIN_BIT] = cmp_gt[2];
      end
      vpt_pkg::ADDR_LAG_STATUS: begin
        rd_word[LAG_W-1:0]                     = s_q.lag_prev;
        rd_word[vpt_pkg::LAG_COUNT_LSB +: 16]  = s_q.lag_frames;
      end
      default: begin
        addr_ok = 1'b0;                         // unmapped: error, zero
      end
    endcase
  end

  // ----------------
  // next state
  // ----------------
  always_comb begin
    s_d = s_q;
    s_d.tone_valid = 1'b0;

    // read data and error captured in setup, shown in the access cycle
    if (setup_phase) begin
      s_d.rdata = pwrite ? 32'h0000_0000 : rd_word;
      s_d.rerr  = !addr_ok;
    end

    // one update per frame, only on the lag strobe
    if (lag_valid) begin                                        // R19
      s_d.near_cur   = near_count;                              // R02
      s_d.near_old   = s_q.near_prev;                           // R03
      s_d.near_prev  = near_count;                              // R03
      s_d.periodic   = (near_sum >= vpt_pkg::NEAR_SUM_MIN);     // R01
      s_d.lag_prev   = lag_second;                              // R04
      s_d.lag_frames = s_q.lag_frames + 16'd1;
    end

    // tone evaluated once the frame's coefficients are present
    if (coeff_valid) begin                                      // R07
      s_d.tone       = tone_next;
      s_d.tone_valid = 1'b1;
    end

    // raw magnitudes are normalized as they are written
    if (wr_access) begin
      unique case (paddr)
        vpt_pkg::ADDR_CTRL: begin
          if (pstrb[0] && pwdata[vpt_pkg::CTRL_RESTART_BIT]) begin
            s_d = STATE_RESET;                                  // R20
          end
        end
        vpt_pkg::ADDR_ENERGY: begin
          {s_d.energy_exp, s_d.energy_mant} = pf_norm(pwdata & wmask);      // R09
        end
        vpt_pkg::ADDR_THRESH: begin
          {s_d.thresh_exp, s_d.thresh_mant} = pf_norm(pwdata & wmask);      // R09
        end
        vpt_pkg::ADDR_FRAME_ENERGY: begin
          {s_d.frame_exp, s_d.frame_mant} = pf_norm(pwdata & wmask);        // R09
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------
  // state register
  // ----------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= STATE_RESET;                                       // R05 R20
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------
  // outputs
  // ----------------
  // zero wait states: every access completes in its first access cycle
  assign pready        = 1'b1;
  assign prdata        = s_q.rdata;
  assign pslverr       = psel && penable && s_q.rerr;
  // the flag seen by this frame's decision is last frame's result
  assign periodic_flag = s_q.periodic;                          // R06
  assign tone_flag     = s_q.tone;
  assign tone_valid    = s_q.tone_valid;

endmodule : vpt_core

// file: verif/vpt_core_properties.sv
// checker for vpt_core: flag timing, tone pulse, apb error and restart.
// assumes it is bound to vpt_core and sees only its ports.
`timescale 1ns/1ps

module vpt_core_properties #(
  parameter int LAG_W = 8
) (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset,
  // apb
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic                    pslverr,
  // encoder side
  input wire logic                    lag_valid,
  input wire logic [LAG_W-1:0]        lag_first,
  input wire logic [LAG_W-1:0]        lag_second,
  input wire logic                    coeff_valid,
  input wire logic signed [15:0]      reflection_coeff_2,
  input wire logic [15:0]             norm_pred_error,
  // results
  input wire logic                    periodic_flag,
  input wire logic                    tone_flag,
  input wire logic                    tone_valid
);
  // ----------------
  // helpers and assertions
  // ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // a write to ctrl may be a restart, so hold checks exclude all writes
  logic             wr;
  logic             restart;
  logic [LAG_W-1:0] gap;
  assign wr      = psel && penable && pwrite;
  assign restart = wr && paddr == vpt_pkg::ADDR_CTRL && pstrb[0] && pwdata[0];
  assign gap     = (lag_first > lag_second) ? lag_first - lag_second : lag_second - lag_first;

  a_reset_flag: assert property ($fell(reset) |-> periodic_flag && !tone_valid)
    else $error("periodic flag not set after reset");
  a_flag_holds: assert property (!lag_valid && !wr |=> $stable(periodic_flag))
    else $error("periodic flag moved without lag strobe");
  a_far_pair: assert property (lag_valid && !wr && gap >= 2 |=> !periodic_flag)
    else $error("periodic flag set with far second pair");
  a_restart_sets: assert property (restart |=> periodic_flag)
    else $error("restart did not set periodic flag");
  a_tone_pulse: assert property (coeff_valid && !restart |=>
    tone_valid ##1 (tone_valid == ($past(coeff_valid) && !$past(restart))))
    else $error("tone valid not a single pulse");
  a_tone_cause: assert property (tone_valid |-> $past(coeff_valid))
    else $error("tone valid without coefficients");
  a_tone_holds: assert property (!coeff_valid && !wr |=> $stable(tone_flag))
    else $error("tone flag moved without coefficients");
  a_error_high: assert property (coeff_valid && !wr && norm_pred_error >= 16'h05B8 |=> !tone_flag)
    else $error("tone set with large prediction error");
  a_im_negative: assert property (coeff_valid && !wr && reflection_coeff_2[15] |=> !tone_flag)
    else $error("tone set with real poles");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");

  c_periodic: cover property (lag_valid ##1 periodic_flag);
  c_tone: cover property (tone_valid && tone_flag);
  c_slverr: cover property (pslverr);
endmodule : vpt_core_properties

// file: verif/vpt_encoder_model.sv
// encoder-side model: pitch lags and reflection data as one-cycle strobes.
// assumes the bench calls its tasks just after a rising clk_sys edge.
`timescale 1ns/1ps

module vpt_encoder_model (
  // clock
  input  wire logic          clk_sys,
  // strobes and data
  output logic               lag_valid,
  output logic [7:0]         lag_first,
  output logic [7:0]         lag_second,
  output logic               coeff_valid,
  output logic signed [15:0] reflection_coeff_1,
  output logic signed [15:0] reflection_coeff_2,
  output logic [15:0]        norm_pred_error
);
  // idle at time zero
  initial begin
    {lag_valid, coeff_valid} = 2'b00;
    {lag_first, lag_second} = 16'h0000;
    {reflection_coeff_1, reflection_coeff_2, norm_pred_error} = 48'h0;
  end

  // released lines show the inverse so a stale value is never trusted
  task send_lags(input logic [7:0] a, input logic [7:0] b);
    lag_valid <= 1'b1;
    lag_first <= a;
    lag_second <= b;
    @(posedge clk_sys);
    lag_valid <= 1'b0;
    lag_first <= ~a;
    lag_second <= ~b;
  endtask : send_lags

  // every coefficient arrives with the one strobe
  task send_coeffs(input logic signed [15:0] c1, input logic signed [15:0] c2, input logic [15:0] e);
    coeff_valid <= 1'b1;
    reflection_coeff_1 <= c1;
    reflection_coeff_2 <= c2;
    norm_pred_error <= e;
    @(posedge clk_sys);
    coeff_valid <= 1'b0;
    reflection_coeff_1 <= ~c1;
    reflection_coeff_2 <= ~c2;
    norm_pred_error <= ~e;
  endtask : send_coeffs
endmodule : vpt_encoder_model

// file: verif/vpt_core_tb.sv
// self-checking bench for vpt_core: apb master, reference models, verdict.
// assumes the encoder model drives the lag and coefficient inputs.
`timescale 1ns/1ps

module vpt_core_tb;
  // ----------------
  // signals
  // ----------------
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, er;
  logic lag_valid, coeff_valid, periodic_flag, tone_flag, tone_valid;
  logic [7:0] paddr, lag_first, lag_second;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb;
  logic signed [15:0] reflection_coeff_1, reflection_coeff_2, k1, k2;
  logic [15:0] norm_pred_error, e;
  int seed = 38271;
  int bad_count = 0;
  int n_checks = 0;
  int lp = 18, np = 0, no = 0, per = 1, w;
  logic [31:0] tbl [8] = '{32'h0, 32'h64, 32'h0001_FBCF, 32'h0001_FBD0, 32'h0005_4A2F, 32'h0005_4A30,
                           32'h042C_1D80, 32'hFFFF_FFFF};

  vpt_core #(.LAG_W(8)) dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .lag_valid, .lag_first, .lag_second, .coeff_valid, .reflection_coeff_1,
    .reflection_coeff_2, .norm_pred_error, .periodic_flag, .tone_flag, .tone_valid);
  vpt_encoder_model enc (.clk_sys, .lag_valid, .lag_first, .lag_second, .coeff_valid, .reflection_coeff_1,
    .reflection_coeff_2, .norm_pred_error);

  // ----------------
  // tasks and reference functions
  // ----------------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  // request held until pready is seen high; bounded wait
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0; @(posedge clk_sys);
    if (i >= 20) begin bad_count++; $display("wrong value at %0t: no pready", $time); tally_and_finish; end
  endtask : apb

  function automatic logic [31:0] pf(input logic [31:0] x);
    int m;
    logic [31:0] r;
    m = -1;
    for (int i = 0; i < 32; i++) if (x[i]) m = i;
    if (m < 0) return 32'h0;
    r = (m >= 14) ? x >> (m - 14) : x << (14 - m);
    return {16'(m + 1), r[15:0]};
  endfunction : pf

  // exponents first, mantissas on a tie
  function automatic logic lt(input logic [31:0] a, input logic [31:0] b);
    return a[31:16] < b[31:16] || (a[31:16] == b[31:16] && a[15:0] < b[15:0]);
  endfunction : lt

  function automatic int gap(input int x, input int y);
    return x > y ? x - y : y - x;
  endfunction : gap

  function automatic logic tone_ref(input longint c1, input longint c2, input longint pe);
    longint a1, num;
    a1 = c1 + ((c1 * c2) >>> 15);
    num = 4 * c2 * 32768 - a1 * a1;
    if (num < 0) return 1'b0;
    if (a1 <= 0 && num * 32768 < 3188 * a1 * a1) return 1'b0;
    return pe < 1464;
  endfunction : tone_ref

  // random lags close together so both near counts get exercised
  task frames(input int n);
    int a, b, c;
    for (int f = 0; f < n; f++) begin
      a = 20 + {$random(seed)} % 4;
      b = 20 + {$random(seed)} % 4;
      c = int'(gap(a, lp) < 2) + int'(gap(b, a) < 2);
      no = np;
      np = c;
      per = int'(np + no >= 4);
      lp = b;
      enc.send_lags(8'(a), 8'(b));
      @(posedge clk_sys);
      chk(32'(periodic_flag), 32'(per), "periodic flag");
      apb(1'b0, vpt_pkg::ADDR_STATUS, 32'h0);
      chk(rd & 32'h0000_3331, 32'((c << 12) | (no << 8) | (np << 4) | per), "near counts");
      apb(1'b0, vpt_pkg::ADDR_LAG_STATUS, 32'h0);
      chk(rd & 32'h0000_00FF, 32'(lp), "stored lag");
    end
  endtask : frames

  // ----------------
  // clock and main sequence
  // ----------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hF;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk(32'(periodic_flag), 32'h1, "flag after reset");
    apb(1'b0, vpt_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h0000_3333, 32'h1, "status after reset");
    apb(1'b0, vpt_pkg::ADDR_THRESH, 32'h0);
    chk(rd, 32'h0014_69CB, "threshold start");
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk(32'(er), 32'h1, "unmapped error");
    pstrb <= 4'h3;
    apb(1'b1, vpt_pkg::ADDR_ENERGY, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, vpt_pkg::ADDR_ENERGY, 32'h0);
    chk(rd, pf(32'h0000_FFFF), "byte lanes");
    // boundary values around the floor and limit constants, two values above the margin, then random words
    for (int i = 0; i < 14; i++) begin
      v = (i < 8) ? tbl[i] : $random(seed);
      apb(1'b1, vpt_pkg::ADDR_FRAME_ENERGY, v);
      apb(1'b1, vpt_pkg::ADDR_THRESH, v);
      apb(1'b1, vpt_pkg::ADDR_ENERGY, v);
      apb(1'b0, vpt_pkg::ADDR_ENERGY, 32'h0);
      chk(rd, pf(v), "energy word");
      apb(1'b0, vpt_pkg::ADDR_FRAME_ENERGY, 32'h0);
      chk(rd, pf(v), "frame energy word");
      apb(1'b0, vpt_pkg::ADDR_COMPARE, 32'h0);
      chk(rd & 32'h7, {29'h0, lt(32'h001B_421F, pf(v)), lt(pf(v), 32'h0013_54A3), lt(pf(v), 32'h0011_7EF4)},
          "compare flags");
    end
    frames(30);
    apb(1'b1, vpt_pkg::ADDR_CTRL, 32'h1);
    chk(32'(periodic_flag), 32'h1, "flag after restart");
    lp = 18; np = 0; no = 0; per = 1;
    frames(10);
    for (int i = 0; i < 40; i++) begin
      if (i < 2) begin k1 = 16'sh0000; k2 = 16'sh1F40; e = 16'(1463 + i); end
      else begin k1 = 16'($random(seed) % 16384); k2 = 16'($random(seed) % 16384); e = 16'({$random(seed)} % 3000); end
      enc.send_coeffs(k1, k2, e);
      w = 0;
      while (tone_valid !== 1'b1 && w < 8) begin @(posedge clk_sys); w++; end
      if (w >= 8) begin bad_count++; $display("wrong value at %0t: no tone result", $time); tally_and_finish; end
      chk(32'(tone_flag), 32'(tone_ref(k1, k2, e)), "tone flag");
    end
    tally_and_finish;
  end
endmodule : vpt_core_tb

bind vpt_core vpt_core_properties #(.LAG_W(LAG_W)) u_props (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pslverr, .lag_valid, .lag_first, .lag_second, .coeff_valid, .reflection_coeff_2,
  .norm_pred_error, .periodic_flag, .tone_flag, .tone_valid);
